// file: src/cps_regs.svh
// Offsets, field positions and reset values of the pin and processing bank.
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// ==========================================================================
// Register offsets within page 0.
`define CPS_ADDR_PIN 8'h3a
`define CPS_ADDR_RSVD 8'h3b
`define CPS_ADDR_PLAY 8'h3c
`define CPS_ADDR_REC 8'h3d
`define CPS_ADDR_ENG 8'h3e

// ==========================================================================
// Field positions.
`define CPS_PIN_MODE_HI 6
`define CPS_PIN_MODE_LO 5
`define CPS_PIN_LEVEL_BIT 4
`define CPS_SEL_HI 4
`define CPS_SEL_LO 0
`define CPS_REC_COND_A_BIT 6
`define CPS_REC_COND_B_BIT 5
`define CPS_REC_FREE_BIT 4
`define CPS_PLAY_COND_A_BIT 2
`define CPS_PLAY_COND_B_BIT 1
`define CPS_PLAY_FREE_BIT 0

// ==========================================================================
// Reset values and special codes.
`define CPS_PIN_RST 8'h00
`define CPS_RSVD_RST 8'h00
`define CPS_PLAY_RST 8'h01
`define CPS_REC_RST 8'h04
`define CPS_ENG_RST 8'h00
`define CPS_ROUTE_RST 10'h24a
`define CPS_PLAY_BLOCK_RST 5'h01
`define CPS_REC_BLOCK_RST 5'h04
`define CPS_SEL_ENGINE 5'h00
`define CPS_PIN_OFF_CODE 2'h0
`define CPS_PIN_SEC_CODE 2'h1
`define CPS_PIN_GPI_CODE 2'h2

`endif

// file: src/cps_pkg.sv
// Types shared by the pin and processing select bank.
package cps_pkg;

	// ======================================================================
	// Use of the third input pin.
	typedef enum logic [1:0] {
		CPS_PIN_OFF,
		CPS_PIN_SEC_CLK,
		CPS_PIN_GPI,
		CPS_PIN_RSVD
	} cps_pin_mode_e;

	// Processing select code width.
	typedef logic [4:0] cps_sel_t;

endpackage : cps_pkg

// file: src/cps_pin_input.sv
// Input buffer and routing of the third input pin.
`timescale 1ns/1ps
`include "cps_regs.svh"

module cps_pin_input (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [1:0] mode_i, // Pin mode field.
	input wire logic pin_i, // Pin level, synchronous to clk_i.
	output logic buf_on_o, // Input buffer powered.
	output logic sec_clk_o, // Pin level offered as secondary clock.
	output logic gpi_o, // Pin level offered as general purpose input.
	output logic level_o // Buffer value for readback.
);

	// ======================================================================
	// Mode decode.
	cps_pkg::cps_pin_mode_e mode; // Decoded pin use.
	logic next_buf_on; // Next buffer power.
	logic next_sec_clk; // Next secondary clock value.
	logic next_gpi; // Next input value.
	logic next_level; // Next readback value.

	// The reserved code is treated as off so the buffer draws no current.
	always_comb begin
		case (mode_i)
			`CPS_PIN_OFF_CODE: mode = cps_pkg::CPS_PIN_OFF;
			`CPS_PIN_SEC_CODE: mode = cps_pkg::CPS_PIN_SEC_CLK;
			`CPS_PIN_GPI_CODE: mode = cps_pkg::CPS_PIN_GPI;
			default: mode = cps_pkg::CPS_PIN_RSVD;
		endcase
	end

	// A powered down buffer reads as zero on every output.
	always_comb begin
		next_buf_on = 1'b0;
		next_sec_clk = 1'b0;
		next_gpi = 1'b0;
		case (mode)
			cps_pkg::CPS_PIN_OFF: begin
				next_buf_on = 1'b0;
			end
			cps_pkg::CPS_PIN_SEC_CLK: begin
				next_buf_on = 1'b1;
				next_sec_clk = pin_i;
			end
			cps_pkg::CPS_PIN_GPI: begin
				next_buf_on = 1'b1;
				next_gpi = pin_i;
			end
			default: begin
				next_buf_on = 1'b0;
			end
		endcase
		next_level = next_buf_on & pin_i;
	end

	// Register the pin outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_on_o <= 1'b0;
			sec_clk_o <= 1'b0;
			gpi_o <= 1'b0;
			level_o <= 1'b0;
		end else begin
			buf_on_o <= next_buf_on;
			sec_clk_o <= next_sec_clk;
			gpi_o <= next_gpi;
			level_o <= next_level;
		end
	end

endmodule : cps_pin_input

// file: src/cps_select_bank.sv
// Pin control, processing select and engine control register bank.
`timescale 1ns/1ps
`include "cps_regs.svh"

// Overview of operation
// - Pin mode: off, secondary clock, input.
// - Playback select: zero engine, else fixed block.
// - Record select: zero engine, else fixed block.
// - Record engine gets condition bits A, B.
// - Playback engine gets condition bits A, B.
// - Record counter frame restart choice bit.
// - Playback counter frame restart choice bit.
module cps_select_bank (
	input wire logic clk_i, // System clock, 40 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wr_en_i, // Register write strobe.
	input wire logic rd_en_i, // Register read strobe.
	input wire logic [7:0] addr_i, // Page 0 register offset.
	input wire logic [7:0] wdata_i, // Write data.
	output logic [7:0] rdata_o, // Read data.
	output logic rvalid_o, // Read data valid pulse.
	input wire logic pin_i, // Third input pin level.
	output logic pin_buf_on_o, // Third pin input buffer powered.
	output logic pin_sec_clk_o, // Third pin as secondary clock.
	output logic pin_gpi_o, // Third pin as general purpose input.
	output logic play_use_engine_o, // Playback through engine.
	output logic [4:0] play_block_o, // Playback fixed block number.
	output logic play_sel_ok_o, // Playback code is a defined one.
	output logic rec_use_engine_o, // Record through engine.
	output logic [4:0] rec_block_o, // Record fixed block number.
	output logic rec_sel_ok_o, // Record code is a defined one.
	output logic rec_cond_a_o, // Record engine condition A.
	output logic rec_cond_b_o, // Record engine condition B.
	output logic rec_frame_restart_o, // Record counter restarts per frame.
	output logic play_cond_a_o, // Playback engine condition A.
	output logic play_cond_b_o, // Playback engine condition B.
	output logic play_frame_restart_o // Playback counter restarts per frame.
);

	// ======================================================================
	// Code checks used for the routing outputs only; stored values are not checked.

	// Defined playback codes: engine, blocks 1 to 4, 24 and 25.
	function automatic logic play_code_ok(input cps_pkg::cps_sel_t c);
		play_code_ok = (c <= 5'h04) || (c == 5'h18) || (c == 5'h19);
	endfunction : play_code_ok

	// Defined record codes: engine and three groups of three blocks.
	function automatic logic rec_code_ok(input cps_pkg::cps_sel_t c);
		rec_code_ok = (c == 5'h00) || ((c >= 5'h04) && (c <= 5'h06)) ||
			((c >= 5'h0a) && (c <= 5'h0c)) ||
			((c >= 5'h10) && (c <= 5'h12));
	endfunction : rec_code_ok

	// ======================================================================
	// Register storage.
	logic [7:0] pin_ctl; // Third pin control, level bit not stored.
	logic [7:0] rsvd_reg; // Reserved register, kept as plain storage.
	logic [7:0] play_sel; // Playback processing select.
	logic [7:0] rec_sel; // Record processing select.
	logic [7:0] eng_ctl; // Engine condition and restart bits.
	logic [7:0] next_pin_ctl; // Next pin control.
	logic [7:0] next_rsvd_reg; // Next reserved register.
	logic [7:0] next_play_sel; // Next playback select.
	logic [7:0] next_rec_sel; // Next record select.
	logic [7:0] next_eng_ctl; // Next engine control.
	logic pin_level; // Registered pin buffer value.

	// Writes store the byte as given, pin level bit cleared; reserved bits and reserved codes
	// are kept so software reads back what it wrote, as the host side
	// is trusted to write only zeros and defined codes there.
	always_comb begin
		next_pin_ctl = pin_ctl;
		next_rsvd_reg = rsvd_reg;
		next_play_sel = play_sel;
		next_rec_sel = rec_sel;
		next_eng_ctl = eng_ctl;
		if (wr_en_i) begin
			case (addr_i)
				`CPS_ADDR_PIN: begin
					next_pin_ctl = wdata_i;
					next_pin_ctl[`CPS_PIN_LEVEL_BIT] = 1'b0;
				end
				`CPS_ADDR_RSVD: begin
					next_rsvd_reg = wdata_i;
				end
				`CPS_ADDR_PLAY: begin
					next_play_sel = wdata_i;
				end
				`CPS_ADDR_REC: begin
					next_rec_sel = wdata_i;
				end
				`CPS_ADDR_ENG: begin
					next_eng_ctl = wdata_i;
				end
				default: begin
					next_pin_ctl = pin_ctl;
				end
			endcase
		end
	end

	// Register the bank; reset selects block 1 and block 4.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ctl <= `CPS_PIN_RST;
			rsvd_reg <= `CPS_RSVD_RST;
			play_sel <= `CPS_PLAY_RST;
			rec_sel <= `CPS_REC_RST;
			eng_ctl <= `CPS_ENG_RST;
		end else begin
			pin_ctl <= next_pin_ctl;
			rsvd_reg <= next_rsvd_reg;
			play_sel <= next_play_sel;
			rec_sel <= next_rec_sel;
			eng_ctl <= next_eng_ctl;
		end
	end

	// ======================================================================
	// Third pin input buffer.
	cps_pin_input cps_pin_input_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mode_i(pin_ctl[`CPS_PIN_MODE_HI:`CPS_PIN_MODE_LO]),
		.pin_i(pin_i),
		.buf_on_o(pin_buf_on_o),
		.sec_clk_o(pin_sec_clk_o),
		.gpi_o(pin_gpi_o),
		.level_o(pin_level)
	);

	// ======================================================================
	// Read port.
	logic [7:0] next_rdata; // Next read data.
	logic next_rvalid; // Next read valid.

	// Unmapped offsets read as zero; the level bit shows the registered buffer value, zero when the buffer is off.
	always_comb begin
		next_rdata = 8'h00;
		next_rvalid = rd_en_i;
		if (rd_en_i) begin
			case (addr_i)
				`CPS_ADDR_PIN: begin
					next_rdata = pin_ctl;
					next_rdata[`CPS_PIN_LEVEL_BIT] = pin_level;
				end
				`CPS_ADDR_RSVD: next_rdata = rsvd_reg;
				`CPS_ADDR_PLAY: next_rdata = play_sel;
				`CPS_ADDR_REC: next_rdata = rec_sel;
				`CPS_ADDR_ENG: next_rdata = eng_ctl;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Read data holds until the next read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= next_rvalid;
			if (next_rvalid) begin
				rdata_o <= next_rdata;
			end
		end
	end

	// ======================================================================
	// Routing and engine control outputs.
	cps_pkg::cps_sel_t play_code; // Current playback code.
	cps_pkg::cps_sel_t rec_code; // Current record code.
	logic [9:0] next_route; // Next routing and engine outputs.
	logic [9:0] route; // Registered routing and engine outputs.
	logic [4:0] route_play_block; // Registered playback block.
	logic [4:0] route_rec_block; // Registered record block.

	// Block number zero stands for the engine, so the block output is
	// simply the code and the engine flag tests for zero.
	always_comb begin
		play_code = play_sel[`CPS_SEL_HI:`CPS_SEL_LO];
		rec_code = rec_sel[`CPS_SEL_HI:`CPS_SEL_LO];
		next_route[0] = (play_code == `CPS_SEL_ENGINE);
		next_route[1] = play_code_ok(play_code);
		next_route[2] = (rec_code == `CPS_SEL_ENGINE);
		next_route[3] = rec_code_ok(rec_code);
		next_route[4] = eng_ctl[`CPS_REC_COND_A_BIT];
		next_route[5] = eng_ctl[`CPS_REC_COND_B_BIT];
		next_route[6] = ~eng_ctl[`CPS_REC_FREE_BIT];
		next_route[7] = eng_ctl[`CPS_PLAY_COND_A_BIT];
		next_route[8] = eng_ctl[`CPS_PLAY_COND_B_BIT];
		next_route[9] = ~eng_ctl[`CPS_PLAY_FREE_BIT];
	end

	// Reset values mirror what the register reset values decode to.
	// Both restart outputs are high after reset, since a cleared restart
	// bit means the counters restart at every frame.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			route <= `CPS_ROUTE_RST;
			route_play_block <= `CPS_PLAY_BLOCK_RST;
			route_rec_block <= `CPS_REC_BLOCK_RST;
		end else begin
			route <= next_route;
			route_play_block <= play_code;
			route_rec_block <= rec_code;
		end
	end

	assign play_use_engine_o = route[0];
	assign play_sel_ok_o = route[1];
	assign rec_use_engine_o = route[2];
	assign rec_sel_ok_o = route[3];
	assign rec_cond_a_o = route[4];
	assign rec_cond_b_o = route[5];
	assign rec_frame_restart_o = route[6];
	assign play_cond_a_o = route[7];
	assign play_cond_b_o = route[8];
	assign play_frame_restart_o = route[9];
	assign play_block_o = route_play_block;
	assign rec_block_o = route_rec_block;

endmodule : cps_select_bank

// file: verif/cps_select_bank_props.sv
// Port checks of the pin and processing select bank.
`timescale 1ns/1ps
module cps_select_bank_props (
	input wire logic clk_i, // Clock.
	input wire logic rst_i, // Reset.
	input wire logic wr_en_i, // Write.
	input wire logic rd_en_i, // Read.
	input wire logic [7:0] addr_i, // Offset.
	input wire logic [7:0] wdata_i, // Data in.
	input wire logic [7:0] rdata_o, // Data out.
	input wire logic rvalid_o, // Valid.
	input wire logic pin_i, // Pin.
	input wire logic pin_buf_on_o, // Buffer.
	input wire logic pin_sec_clk_o, // Clock use.
	input wire logic pin_gpi_o, // Input use.
	input wire logic play_use_engine_o, // Engine.
	input wire logic [4:0] play_block_o, // Block.
	input wire logic rec_use_engine_o, // Engine.
	input wire logic [4:0] rec_block_o, // Block.
	input wire logic rec_cond_a_o, // Cond A.
	input wire logic rec_cond_b_o, // Cond B.
	input wire logic rec_frame_restart_o, // Restart.
	input wire logic play_cond_a_o, // Cond A.
	input wire logic play_cond_b_o, // Cond B.
	input wire logic play_frame_restart_o // Restart.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] w1, w2; // Write data one and two edges back.
	logic lv; // Gated pin level one edge back.
	// ======================================================================
	// Helpers: written data reaches outputs two edges after the strobe.
	always_ff @(posedge clk_i) begin
		w1 <= wdata_i;
		w2 <= w1;
		lv <= pin_sec_clk_o | pin_gpi_o;
	end
	a_play_follow: assert property (wr_en_i && addr_i == 8'h3c |-> ##2
		play_block_o == w2[4:0] && play_use_engine_o == (w2[4:0] == 5'h00))
		else $error("playback select wrong");
	a_rec_follow: assert property (wr_en_i && addr_i == 8'h3d |-> ##2
		rec_block_o == w2[4:0] && rec_use_engine_o == (w2[4:0] == 5'h00))
		else $error("record select wrong");
	a_cond_follow: assert property (wr_en_i && addr_i == 8'h3e |-> ##2
		{rec_cond_a_o, rec_cond_b_o, play_cond_a_o, play_cond_b_o}
		== {w2[6], w2[5], w2[2], w2[1]}) else $error("condition bits wrong");
	a_restart_sense: assert property (
		wr_en_i && addr_i == 8'h3e |-> ##2
		rec_frame_restart_o == !w2[4] && play_frame_restart_o == !w2[0])
		else $error("restart bits wrong");
	a_pin_buffer: assert property (wr_en_i && addr_i == 8'h3a |-> ##2
		pin_buf_on_o == (w2[6:5] == 2'h1 || w2[6:5] == 2'h2))
		else $error("pin buffer wrong");
	a_pin_route: assert property (pin_gpi_o || pin_sec_clk_o |->
		pin_buf_on_o && $past(pin_i) && !(pin_gpi_o && pin_sec_clk_o))
		else $error("pin routing wrong");
	a_pin_readback: assert property (rd_en_i && addr_i == 8'h3a |=>
		rdata_o[4] == lv) else $error("pin level read wrong");
	a_read_pulse: assert property (!$past(rst_i) |->
		rvalid_o == $past(rd_en_i)) else $error("read valid wrong");
	a_unmapped_zero: assert property (rd_en_i && (addr_i < 8'h3a
		|| addr_i > 8'h3e) |=> rdata_o == 8'h00) else $error("unmapped read");
endmodule : cps_select_bank_props

// file: verif/cps_select_bank_test.sv
// Directed register and output test of the select bank.
`timescale 1ns/1ps
module cps_select_bank_test;
	logic clk_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
	logic pin_i = 1'b0; // Pin level.
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic rvalid_o, pin_buf_on_o, pin_sec_clk_o, pin_gpi_o;
	logic play_use_engine_o, play_sel_ok_o, rec_use_engine_o, rec_sel_ok_o;
	logic rec_cond_a_o, rec_cond_b_o, rec_frame_restart_o;
	logic play_cond_a_o, play_cond_b_o, play_frame_restart_o;
	logic [4:0] play_block_o, rec_block_o;
	int bad_count = 0, total_checks = 0;
	logic [7:0] d; // Engine pattern.
	int play_codes[7] = '{0, 1, 2, 3, 4, 24, 25}; // Defined playback codes.
	int rec_codes[10] = '{0, 4, 5, 6, 10, 11, 12, 16, 17, 18}; // Record.
	int c; // Select code under test.
	logic on; // Expected buffer state.
	// Output groups packed into bytes for one compare task.
	wire logic [7:0] play_v = {1'b0, play_use_engine_o, play_sel_ok_o,
		play_block_o};
	wire logic [7:0] rec_v = {1'b0, rec_use_engine_o, rec_sel_ok_o,
		rec_block_o};
	wire logic [7:0] eng_v = {2'h0, rec_cond_a_o, rec_cond_b_o,
		rec_frame_restart_o, play_cond_a_o, play_cond_b_o, play_frame_restart_o};
	wire logic [7:0] pin_v = {5'h00, pin_buf_on_o, pin_sec_clk_o, pin_gpi_o};
	// ======================================================================
	// Clock of 25 ns.
	always #12.5 clk_i = ~clk_i;
	cps_select_bank cps_select_bank_inst (.clk_i, .rst_i, .wr_en_i, .rd_en_i,
		.addr_i, .wdata_i, .rdata_o, .rvalid_o, .pin_i, .pin_buf_on_o,
		.pin_sec_clk_o, .pin_gpi_o, .play_use_engine_o, .play_block_o,
		.play_sel_ok_o, .rec_use_engine_o, .rec_block_o, .rec_sel_ok_o,
		.rec_cond_a_o, .rec_cond_b_o, .rec_frame_restart_o, .play_cond_a_o,
		.play_cond_b_o, .play_frame_restart_o);
	task chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask : chk
	// Write, then wait until derived outputs have followed.
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		chk({7'h00, rvalid_o}, 8'h01);
		chk(rdata_o, e);
	endtask : rd
	task rst_chk;
		chk(play_v, 8'h21);
		chk(rec_v, 8'h24);
		chk(eng_v, 8'h09);
		chk(pin_v, 8'h00);
		rd(8'h3a, 8'h00);
		rd(8'h3c, 8'h01);
		rd(8'h3d, 8'h04);
		rd(8'h3e, 8'h00);
	endtask : rst_chk
	task close_out;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	// ======================================================================
	// Watchdog well beyond the expected run of about 6 us.
	initial begin
		#300000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		rst_chk();
		// Only defined codes are written: the host keeps off reserved ones.
		for (int k = 0; k < 7; k++) begin
			c = play_codes[k];
			wr(8'h3c, {3'h0, c[4:0]});
			chk(play_v, {1'b0, c == 0, c inside {[0:4], 24, 25}, c[4:0]});
			rd(8'h3c, {3'h0, c[4:0]});
		end
		for (int k = 0; k < 10; k++) begin
			c = rec_codes[k];
			wr(8'h3d, {3'h0, c[4:0]});
			chk(rec_v, {1'b0, c == 0,
				c inside {0, [4:6], [10:12], [16:18]}, c[4:0]});
			rd(8'h3d, {3'h0, c[4:0]});
		end
		// One engine bit at a time catches swapped positions.
		for (int i = 0; i < 9; i++) begin
			d = (i == 8) ? 8'h00 : 8'h01 << i;
			wr(8'h3e, d);
			chk(eng_v, {2'h0, d[6:5], !d[4], d[2:1], !d[0]});
			rd(8'h3e, d);
		end
		// Pin modes at both levels; the written level bit must not stick.
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge clk_i);
				pin_i <= p[0];
				wr(8'h3a, {1'b0, m[1:0], 5'h10});
				on = (m == 1 || m == 2);
				chk(pin_v, {5'h00, on, m == 1 && p == 1, m == 2 && p == 1});
				rd(8'h3a, {1'b0, m[1:0], on && p == 1, 4'h0});
			end
		end
		wr(8'h3b, 8'h00);
		rd(8'h3b, 8'h00);
		wr(8'h39, 8'hff);
		rd(8'h39, 8'h00);
		rd(8'h3f, 8'h00);
		// Reset in mid-run restores the pin, select and engine registers.
		wr(8'h3e, 8'h77);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		rst_chk();
		close_out();
	end
endmodule : cps_select_bank_test
bind cps_select_bank cps_select_bank_props cps_select_bank_props_inst (
	.clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o,
	.rvalid_o, .pin_i, .pin_buf_on_o, .pin_sec_clk_o, .pin_gpi_o,
	.play_use_engine_o, .play_block_o, .rec_use_engine_o, .rec_block_o,
	.rec_cond_a_o, .rec_cond_b_o, .rec_frame_restart_o, .play_cond_a_o,
	.play_cond_b_o, .play_frame_restart_o);
